// ### src/timer2_pkg.sv
package timer2_pkg;

	// -----------------------------------------------------------------
	// Register addresses
	// -----------------------------------------------------------------
	localparam logic [7:0] ADDR_TIMER_CONTROL        = 8'hc8;
	localparam logic [7:0] ADDR_TIMER_MODE_CFG       = 8'hc9;
	localparam logic [7:0] ADDR_RELOAD_COMPARE_LOW   = 8'hca;
	localparam logic [7:0] ADDR_RELOAD_COMPARE_HIGH  = 8'hcb;
	localparam logic [7:0] ADDR_COUNT_LOW_BYTE       = 8'hcc;
	localparam logic [7:0] ADDR_COUNT_HIGH_BYTE      = 8'hcd;
	localparam logic       COUNT_PAGE                = 1'b0;

	// -----------------------------------------------------------------
	// Control register field positions
	// -----------------------------------------------------------------
	localparam int FLAG_BIT                  = 7;
	localparam int RUN_CONTROL_BIT           = 2;
	localparam int COMPARE_RELOAD_SELECT_BIT = 0;

	// -----------------------------------------------------------------
	// Reset, clear and wrap values
	// -----------------------------------------------------------------
	localparam logic [7:0]  RESET_BYTE  = 8'h00;
	localparam logic [15:0] RESET_COUNT = 16'h0000;
	localparam logic [15:0] CLEAR_COUNT = 16'h0000;
	localparam logic [15:0] COUNT_TOP   = 16'hffff;

	// -----------------------------------------------------------------
	// Trigger selection codes
	// -----------------------------------------------------------------
	localparam logic [1:0] TRIGGER_OVERFLOW = 2'h0;

	// -----------------------------------------------------------------
	// Mode register layout, bit 7 down to bit 0
	// -----------------------------------------------------------------
	typedef struct packed {
		logic       reload_enable;
		logic [2:0] count_clock_divider;
		logic       capture_clear_enable;
		logic       match_clear_enable;
		logic [1:0] reload_trigger_select;
	} timer_mode_cfg_t;

	// Terminal prescaler count for each divider code.
	function automatic logic [8:0] divider_terminal(input logic [2:0] code);
		logic [8:0] term;
		term = 9'h000;
		case (code)
			3'h0: term = 9'h000;
			3'h1: term = 9'h003;
			3'h2: term = 9'h00f;
			3'h3: term = 9'h01f;
			3'h4: term = 9'h03f;
			3'h5: term = 9'h07f;
			3'h6: term = 9'h0ff;
			default: term = 9'h1ff;
		endcase
		return term;
	endfunction

endpackage

// ### src/count_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module count_prescaler (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       clk_en,
	// Control
	input  wire logic       run,
	input  wire logic [2:0] divider_code,
	// Divided tick
	output logic            tick
);

	logic [8:0] div_count;
	logic [8:0] next_div_count;
	wire  [8:0] terminal = timer2_pkg::divider_terminal(divider_code);
	wire        at_end   = div_count >= terminal;

	// A halted timer restarts its division from zero.
	assign next_div_count = (!run || at_end) ? 9'h000 : div_count + 9'h001;
	assign tick           = run && at_end;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			div_count <= 9'h000;
		end else if (clk_en) begin
			div_count <= next_div_count;
		end
	end

endmodule
`default_nettype wire

// ### src/timer2_reload_compare_core.sv
`timescale 1ns/1ps
`default_nettype none
module timer2_reload_compare_core (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        clk_en,
	// Register port
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_page,
	input  wire logic        sfr_wr,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic        sfr_rd,
	output logic      [7:0]  sfr_rdata,
	output logic             sfr_rdata_valid,
	// Capture events
	input  wire logic [2:0]  capture_event,
	// Status
	output logic             overflow_match_flag,
	output logic      [15:0] timer_count
);

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	timer2_pkg::timer_mode_cfg_t mode_cfg;
	logic [15:0] reload_compare;
	logic        run_control;
	logic        compare_reload_select;

	// -----------------------------------------------------------------
	// Address decode
	// -----------------------------------------------------------------
	wire count_page = sfr_page == timer2_pkg::COUNT_PAGE;
	wire sel_ctrl   = sfr_addr == timer2_pkg::ADDR_TIMER_CONTROL;
	wire sel_mode   = sfr_addr == timer2_pkg::ADDR_TIMER_MODE_CFG;
	wire sel_rcl    = sfr_addr == timer2_pkg::ADDR_RELOAD_COMPARE_LOW;
	wire sel_rch    = sfr_addr == timer2_pkg::ADDR_RELOAD_COMPARE_HIGH;
	wire sel_cl     = count_page &&
			  sfr_addr == timer2_pkg::ADDR_COUNT_LOW_BYTE;
	wire sel_ch     = count_page &&
			  sfr_addr == timer2_pkg::ADDR_COUNT_HIGH_BYTE;
	wire sel_any    = sel_ctrl || sel_mode || sel_rcl || sel_rch ||
			  sel_cl || sel_ch;

	// -----------------------------------------------------------------
	// Counting events
	// -----------------------------------------------------------------
	wire       tick;
	wire       compare_mode = compare_reload_select;
	wire       any_capture  = |capture_event;
	wire       wrap         = tick && timer_count == timer2_pkg::COUNT_TOP;
	wire       match        = compare_mode && tick &&
				  timer_count == reload_compare;
	wire [1:0] trig_sel     = mode_cfg.reload_trigger_select;
	wire [1:0] cap_index    = trig_sel - 2'h1;
	wire       trig_event   = (trig_sel == timer2_pkg::TRIGGER_OVERFLOW) ?
				  wrap : capture_event[cap_index];
	wire       do_reload    = !compare_mode && mode_cfg.reload_enable &&
				  trig_event;
	wire       do_cap_clr   = !compare_mode && any_capture &&
				  mode_cfg.capture_clear_enable;
	wire       do_match_clr = match && mode_cfg.match_clear_enable;
	wire       hw_update    = tick || do_reload || do_cap_clr;
	wire       wr_count     = sfr_wr && (sel_cl || sel_ch);

	// -----------------------------------------------------------------
	// Next values
	// -----------------------------------------------------------------
	logic [15:0] next_count;
	always_comb begin
		next_count = timer_count;
		if (do_reload) begin
			next_count = reload_compare;
		end else if (do_cap_clr || do_match_clr) begin
			next_count = timer2_pkg::CLEAR_COUNT;
		end else if (tick) begin
			next_count = timer_count + 16'h0001;
		end else if (sfr_wr && sel_cl) begin
			next_count = {timer_count[15:8], sfr_wdata};
		end else if (sfr_wr && sel_ch) begin
			next_count = {sfr_wdata, timer_count[7:0]};
		end
	end

	logic [15:0] next_reload_compare;
	always_comb begin
		next_reload_compare = reload_compare;
		if (any_capture) begin
			next_reload_compare = timer_count;
		end else if (sfr_wr && sel_rcl) begin
			next_reload_compare = {reload_compare[15:8], sfr_wdata};
		end else if (sfr_wr && sel_rch) begin
			next_reload_compare = {sfr_wdata, reload_compare[7:0]};
		end
	end

	wire sw_flag   = (sfr_wr && sel_ctrl) ? sfr_wdata[timer2_pkg::FLAG_BIT] :
			 overflow_match_flag;
	wire next_flag = wrap || match || sw_flag;

	wire [7:0] ctrl_read = {overflow_match_flag, 4'h0, run_control,
				1'b0, compare_reload_select};
	wire [7:0] read_mux  = sel_ctrl ? ctrl_read :
			       sel_mode ? mode_cfg :
			       sel_rcl  ? reload_compare[7:0] :
			       sel_rch  ? reload_compare[15:8] :
			       sel_cl   ? timer_count[7:0] :
			       sel_ch   ? timer_count[15:8] : 8'h00;

	// -----------------------------------------------------------------
	// Prescaler
	// -----------------------------------------------------------------
	count_prescaler u_prescaler (
		.mclk         (mclk),
		.reset        (reset),
		.clk_en       (clk_en),
		.run          (run_control),
		.divider_code (mode_cfg.count_clock_divider),
		.tick         (tick)
	);

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			timer_count    <= timer2_pkg::RESET_COUNT;
			reload_compare <= timer2_pkg::RESET_COUNT;
		end else if (clk_en) begin
			timer_count    <= next_count;
			reload_compare <= next_reload_compare;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			mode_cfg              <= timer2_pkg::RESET_BYTE;
			run_control           <= 1'b0;
			compare_reload_select <= 1'b0;
			overflow_match_flag   <= 1'b0;
		end else if (clk_en) begin
			overflow_match_flag <= next_flag;
			if (sfr_wr && sel_mode) begin
				mode_cfg <= sfr_wdata;
			end
			if (sfr_wr && sel_ctrl) begin
				run_control <=
				    sfr_wdata[timer2_pkg::RUN_CONTROL_BIT];
				compare_reload_select <=
				    sfr_wdata[timer2_pkg::COMPARE_RELOAD_SELECT_BIT];
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			sfr_rdata       <= 8'h00;
			sfr_rdata_valid <= 1'b0;
		end else if (clk_en) begin
			sfr_rdata       <= (sfr_rd && sel_any) ? read_mux : 8'h00;
			sfr_rdata_valid <= sfr_rd && sel_any;
		end
	end

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	AST_NO_RELOAD_DISABLED: assert property (
		clk_en && !mode_cfg.reload_enable && wrap |=>
		timer_count == timer2_pkg::CLEAR_COUNT)
		else $error("overflow reloaded while reload disabled");

	AST_COUNT_QUIET: assert property (
		clk_en && !mode_cfg.reload_enable && !tick && !any_capture &&
		!wr_count |=> $stable(timer_count))
		else $error("count changed without cause");

	AST_RELOAD_LOADS: assert property (
		clk_en && do_reload |=> timer_count == $past(reload_compare))
		else $error("reload did not load value");

	AST_CAPTURE_COPY: assert property (
		clk_en && any_capture |=> reload_compare == $past(timer_count))
		else $error("capture copy missing");

	AST_CAPTURE_CLEAR: assert property (
		clk_en && do_cap_clr && !do_reload |=> timer_count == 16'h0000)
		else $error("capture clear missing");

	AST_MATCH_CLEAR: assert property (
		clk_en && do_match_clr |=> timer_count == 16'h0000)
		else $error("match clear missing");

	AST_HALT_HOLDS: assert property (
		clk_en && !run_control && !any_capture &&
		!(sfr_wr && (sel_cl || sel_ch)) |=> $stable(timer_count))
		else $error("halted counter moved");

	AST_FLAG_SET: assert property (
		clk_en && (wrap || match) |=> overflow_match_flag)
		else $error("flag not set");

	AST_FLAG_STICKY: assert property (
		overflow_match_flag && !(sfr_wr && sel_ctrl) |=> overflow_match_flag)
		else $error("flag cleared by hardware");

	AST_INCREMENT: assert property (
		clk_en && tick && !do_reload && !do_cap_clr && !do_match_clr
		|=> timer_count == $past(timer_count) + 16'h0001)
		else $error("count did not increment");

	AST_PAGE_ONE_IGNORED: assert property (
		clk_en && sfr_wr && sfr_page && !hw_update &&
		(sfr_addr == timer2_pkg::ADDR_COUNT_LOW_BYTE ||
		 sfr_addr == timer2_pkg::ADDR_COUNT_HIGH_BYTE) |=>
		$stable(timer_count))
		else $error("page one write hit counter");

	AST_HW_PRIORITY: assert property (
		clk_en && tick && !do_reload && !do_cap_clr && !do_match_clr &&
		sfr_wr && sel_cl |=> timer_count == $past(timer_count) + 16'h0001)
		else $error("software write beat hardware");

	AST_FREEZE: assert property (
		!clk_en |=> $stable(timer_count) && $stable(reload_compare) &&
		$stable(overflow_match_flag) && $stable(sfr_rdata_valid))
		else $error("state moved while clock enable low");

	AST_DIVIDE_ONE: assert property (
		run_control && mode_cfg.count_clock_divider == 3'h0 |-> tick)
		else $error("undivided clock missed a tick");

	AST_TICK_SPACING: assert property (
		clk_en && tick && mode_cfg.count_clock_divider != 3'h0 &&
		!(sfr_wr && sel_mode) |=> !tick)
		else $error("divided tick came too soon");

	AST_READ_PAGE_ONE: assert property (
		clk_en && sfr_rd && sfr_page &&
		(sfr_addr == timer2_pkg::ADDR_COUNT_LOW_BYTE ||
		 sfr_addr == timer2_pkg::ADDR_COUNT_HIGH_BYTE) |=> !sfr_rdata_valid)
		else $error("page one read hit counter");

	AST_READ_COUNT: assert property (
		clk_en && sfr_rd && sel_ch |=>
		{sfr_rdata, 8'h00} == ($past(timer_count) & 16'hff00))
		else $error("count high byte read wrong");

	AST_VALID_PULSE: assert property (
		clk_en && !sfr_rd |=> !sfr_rdata_valid)
		else $error("read valid without a read");

	AST_RDATA_ZERO: assert property (
		!sfr_rdata_valid |-> sfr_rdata == 8'h00)
		else $error("read data without valid");

	AST_RC_WRITE: assert property (
		clk_en && sfr_wr && sel_rch && !any_capture |=>
		reload_compare[15:8] == $past(sfr_wdata))
		else $error("compare high byte write lost");

	AST_COMPARE_CAPTURE: assert property (
		clk_en && compare_mode && any_capture && !tick && !wr_count
		|=> $stable(timer_count))
		else $error("capture moved count in compare mode");

	AST_CAPTURE_KEEPS: assert property (
		clk_en && any_capture && !mode_cfg.capture_clear_enable &&
		!do_reload && !tick && !wr_count |=> $stable(timer_count))
		else $error("capture cleared count while clear off");

	AST_FLAG_CLEAR: assert property (
		clk_en && sfr_wr && sel_ctrl &&
		!sfr_wdata[timer2_pkg::FLAG_BIT] && !wrap && !match
		|=> !overflow_match_flag)
		else $error("software clear lost");

	AST_OVERFLOW_WRAP: assert property (
		clk_en && wrap && !do_reload |=>
		timer_count == timer2_pkg::CLEAR_COUNT)
		else $error("wrap did not reach zero");

	// -----------------------------------------------------------------
	// Cover points
	// -----------------------------------------------------------------
	COV_OVERFLOW_RELOAD: cover property (clk_en && do_reload && wrap);
	COV_CAPTURE_CLEAR: cover property (clk_en && do_cap_clr);
	COV_MATCH_CLEAR: cover property (clk_en && do_match_clr);
	COV_READ: cover property (sfr_rdata_valid);
	COV_CLOCK_HOLD: cover property (!clk_en && run_control);

endmodule
`default_nettype wire

// ### testbench/timer2_reload_compare_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin errors++; \
	$display("MISMATCH %0t %s", $time, m); end end
module timer2_reload_compare_core_tb_top;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic        mclk;
	logic        reset;
	logic        clk_en;
	logic [7:0]  sfr_addr;
	logic        sfr_page;
	logic        sfr_wr;
	logic [7:0]  sfr_wdata;
	logic        sfr_rd;
	logic [7:0]  sfr_rdata;
	logic        sfr_rdata_valid;
	logic [2:0]  capture_event;
	logic        overflow_match_flag;
	logic [15:0] timer_count;
	int          errors;
	int          compares;
	int          k;
	logic [7:0]  rd_data;
	logic        rd_valid;
	logic [15:0] snap;
	typedef struct {
		logic [7:0] addr;
		logic       page;
		logic [7:0] wdata;
		logic [7:0] exp;
		logic       valid;
	} row_t;
	row_t rows [9] = '{'{8'hc9, 1'b0, 8'ha5, 8'ha5, 1'b1},
		'{8'hca, 1'b0, 8'h5a, 8'h5a, 1'b1}, '{8'hcb, 1'b0, 8'hc3, 8'hc3, 1'b1},
		'{8'hcc, 1'b0, 8'h12, 8'h12, 1'b1}, '{8'hcd, 1'b0, 8'h34, 8'h34, 1'b1},
		'{8'hcc, 1'b1, 8'h77, 8'h00, 1'b0}, '{8'hcd, 1'b1, 8'h88, 8'h00, 1'b0},
		'{8'hc7, 1'b0, 8'h99, 8'h00, 1'b0}, '{8'hc8, 1'b0, 8'hfa, 8'h80, 1'b1}};
	timer2_reload_compare_core i_dut (.mclk, .reset, .clk_en, .sfr_addr,
		.sfr_page, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .sfr_rdata_valid,
		.capture_event, .overflow_match_flag, .timer_count);
	// ---------------------------------------------------------------
	// Bus tasks
	// ---------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Each access leaves one idle cycle so a strobe never toggles twice.
	task automatic wr(input logic [7:0] a, input logic p, input logic [7:0] d);
		sfr_addr = a;
		sfr_page = p;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		cyc(1);
		sfr_wr = 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic p);
		sfr_addr = a;
		sfr_page = p;
		sfr_rd = 1'b1;
		cyc(1);
		sfr_rd = 1'b0;
		rd_data = sfr_rdata;
		rd_valid = sfr_rdata_valid;
		cyc(1);
	endtask
	task automatic setcnt(input logic [15:0] v);
		wr(8'hcc, 1'b0, v[7:0]);
		wr(8'hcd, 1'b0, v[15:8]);
	endtask
	task automatic pulse(input logic [2:0] m);
		capture_event = m;
		cyc(1);
		capture_event = 3'h0;
		cyc(1);
	endtask
	task automatic wait_flag;
		k = 0;
		while (overflow_match_flag !== 1'b1 && k < 60) begin
			cyc(1);
			k++;
		end
	endtask
	task automatic complete_run;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ---------------------------------------------------------------
	// Clock, watchdog and tests
	// ---------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		$display("MISMATCH %0t watchdog expired", $time);
		complete_run();
	end
	initial begin
		errors = 0;
		compares = 0;
		reset = 1'b1;
		clk_en = 1'b1;
		{sfr_addr, sfr_page, sfr_wr, sfr_wdata, sfr_rd} = '0;
		capture_event = 3'h0;
		cyc(20);
		reset = 1'b0;
		for (int i = 0; i < 9; i++) begin
			wr(rows[i].addr, rows[i].page, rows[i].wdata);
			rd(rows[i].addr, rows[i].page);
			`CHK(rd_data, rows[i].exp, "register readback")
			`CHK(rd_valid, rows[i].valid, "read valid")
		end
		rd(8'hcc, 1'b0);
		`CHK(rd_data, 8'h12, "page 1 write reached count")
		`CHK(timer_count, 16'h3412, "count byte pair")
		$display("test register table done");
		reset = 1'b1;
		cyc(2);
		reset = 1'b0;
		for (int a = 8'hc8; a <= 8'hcd; a++) begin
			rd(8'(a), 1'b0);
			`CHK({rd_valid, rd_data}, 9'h100, "reset value")
		end
		$display("test reset done");
		for (int c = 0; c < 8; c++) begin
			wr(8'hc9, 1'b0, {1'b0, 3'(c), 4'h0});
			wr(8'hc8, 1'b0, 8'h04);
			for (int j = 0; j < 2; j++) begin
				snap = timer_count;
				k = 0;
				while (timer_count === snap && k < 2000) begin
					cyc(1);
					k++;
				end
			end
			`CHK(k, (c == 0) ? 1 : (c == 1) ? 4 : (1 << (c + 2)), "spacing")
			wr(8'hc8, 1'b0, 8'h00);
			snap = timer_count;
			cyc(20);
			`CHK(timer_count, snap, "count moved while halted")
		end
		$display("test divider done");
		for (int le = 0; le < 2; le++) begin
			wr(8'hca, 1'b0, 8'hf0);
			wr(8'hcb, 1'b0, 8'hff);
			wr(8'hc9, 1'b0, {1'(le), 7'h00});
			setcnt(16'hfffe);
			wr(8'hc8, 1'b0, 8'h04);
			wait_flag();
			`CHK(timer_count, le ? 16'hfff0 : 16'h0000, "wrap")
			cyc(5);
			`CHK(overflow_match_flag, 1'b1, "flag not sticky")
			wr(8'hc8, 1'b0, 8'h00);
			`CHK(overflow_match_flag, 1'b0, "flag not cleared")
		end
		$display("test overflow reload done");
		for (int ch = 0; ch < 3; ch++) begin
			for (int cm = 0; cm < 2; cm++) begin
				wr(8'hc8, 1'b0, {7'h00, 1'(cm)});
				wr(8'hc9, 1'b0, {4'h0, 1'b1, 1'b0, 2'(ch + 1)});
				setcnt(16'h1230 + 16'(ch));
				pulse(3'(1 << ch));
				rd(8'hca, 1'b0);
				`CHK(rd_data, 8'h30 + 8'(ch), "capture low")
				rd(8'hcb, 1'b0);
				`CHK(rd_data, 8'h12, "capture high")
				`CHK(timer_count, cm ? 16'h1230 + 16'(ch) : 16'h0, "clr")
			end
		end
		$display("test capture done");
		for (int sel = 1; sel < 4; sel++) begin
			wr(8'hc8, 1'b0, 8'h00);
			wr(8'hca, 1'b0, 8'h55);
			wr(8'hcb, 1'b0, 8'h55);
			wr(8'hc9, 1'b0, {1'b1, 5'h00, 2'(sel)});
			setcnt(16'h0100);
			pulse(3'(1 << (sel - 1)));
			`CHK(timer_count, 16'h5555, "capture reload")
			pulse(3'(1 << (sel % 3)));
			`CHK(timer_count, 16'h5555, "wrong channel reload")
		end
		$display("test reload trigger done");
		for (int mc = 0; mc < 2; mc++) begin
			wr(8'hc8, 1'b0, 8'h00);
			wr(8'hca, 1'b0, 8'h10);
			wr(8'hcb, 1'b0, 8'h00);
			wr(8'hc9, 1'b0, {5'h00, 1'(mc), 2'h0});
			setcnt(16'h000e);
			wr(8'hc8, 1'b0, 8'h05);
			wait_flag();
			`CHK(timer_count, mc ? 16'h0000 : 16'h0011, "match")
			wr(8'hcc, 1'b0, 8'h80);
			`CHK(timer_count[7:0] < 8'h40, 1'b1, "write beat tick")
		end
		$display("test compare done");
		clk_en = 1'b0;
		snap = timer_count;
		wr(8'hc8, 1'b0, 8'h00);
		rd(8'hcc, 1'b0);
		`CHK(timer_count, snap, "count moved while frozen")
		`CHK(rd_valid, 1'b0, "read answered while frozen")
		clk_en = 1'b1;
		cyc(1);
		`CHK(timer_count !== snap, 1'b1, "count did not resume")
		wr(8'hc8, 1'b0, 8'h00);
		$display("test clock enable done");
		complete_run();
	end
endmodule
`default_nettype wire
